/* verilog/srd_map.svh */
// Register map, field positions, reset values and limits of the
// conduction-sense dead-time controller.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH

// Word addresses on the software register port
`define SRD_A_CTRL 8'h00
`define SRD_A_PERIOD 8'h01
`define SRD_A_NOMINAL 8'h02
`define SRD_A_BLANK 8'h03
`define SRD_A_WINLEN 8'h04
`define SRD_A_MANUAL 8'h05
`define SRD_A_TARGET 8'h06
`define SRD_A_STEP 8'h07
`define SRD_A_FLT_THR 8'h08
`define SRD_A_FLT_STEP 8'h09
`define SRD_A_CNT0 8'h0A
`define SRD_A_CNT1 8'h0B
`define SRD_A_ADJ0 8'h0C
`define SRD_A_ADJ1 8'h0D
`define SRD_A_STATUS 8'h0E
`define SRD_A_MASK 8'h0F

// Control field positions
`define SRD_B_EN 0
`define SRD_B_AUTO 1
`define SRD_B_FLTEN 2

// Status and mask layout: done flags then fault flags, per channel
`define SRD_ST_DONE 0
`define SRD_ST_FLT 2
`define SRD_ST_W 4

// Reset values
`define SRD_RST_CTRL 3'h0
`define SRD_RST_PERIOD 16'h03E8
`define SRD_RST_NOMINAL 16'h0190
`define SRD_RST_BLANK 8'h01
`define SRD_RST_WINLEN 8'h0C
`define SRD_RST_MANUAL 16'h0000
`define SRD_RST_TARGET 7'h04
`define SRD_RST_STEP 16'h0001
`define SRD_RST_FLT_THR 7'h01
`define SRD_RST_FLT_STEP 16'h0010

// Conduction count ceiling and adjustment limits
`define SRD_CNT_MAX 7'h7F
`define SRD_ADJ_MAX 17'sh0_7FFF
`define SRD_ADJ_MIN -17'sh0_8000

`endif

/* verilog/srd_pkg.sv */
// Types shared by the conduction-sense dead-time controller.
// Assumes srd_map.svh for the numeric constants.
`include "srd_map.svh"

package srd_pkg;
    // Detection window phases
    typedef enum logic [1:0] {SRD_IDLE, SRD_BLANK, SRD_OPEN} srd_win_t;
    // Signed on-time correction in clock cycles
    typedef logic signed [15:0] srd_adj_t;
endpackage : srd_pkg

/* verilog/srd_ctrl.sv */
// Controller side of a body-diode conduction sense link: generates two
// rectifier gate commands, measures the conduction reports in a window
// after each turn-off and corrects the next turn-off edge.
// Assumes the driver reports are synchronous to mclk and that software
// uses the one-cycle register port.
// Limitation: conduction is counted in whole mclk cycles, so the count
// resolution is one clock period; a falling edge that arrives while the
// same channel's window is still busy is ignored.
//
// Function
// - Window opens on each command falling edge that finds it idle.
// - Count report low time only in window.
// - Window from blanking delay and length.
// - Separate 0..127 count per channel.
// - Long conduction lengthens next on time.
// - Short conduction shortens next on time.
// - Measure now, correct the following cycle.
// - Manual mode uses software adjustment register.
// - Auto mode steps edge toward target.
// - Below threshold in auto mode, cut on time largely.
// - Per channel window after its pulse falls.
`timescale 1ns/1ps
`include "srd_map.svh"

module srd_ctrl
    import srd_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    input wire logic controller_conduction_input_zero,
    input wire logic controller_conduction_input_one,
    output logic rectifier_zero_pulse,
    output logic rectifier_one_pulse
);

    // Saturate a widened sum back into the adjustment range
    function automatic srd_adj_t srd_sat(input logic signed [16:0] v);
        if (v > `SRD_ADJ_MAX)
            srd_sat = srd_adj_t'(`SRD_ADJ_MAX);
        else if (v < `SRD_ADJ_MIN)
            srd_sat = srd_adj_t'(`SRD_ADJ_MIN);
        else
            srd_sat = v[15:0];
    endfunction : srd_sat

    // Clamp nominal plus correction into 0..half period.
    // The clamp keeps a runaway correction from spilling a channel's
    // pulse into the other half, which would short the two rectifiers.
    function automatic logic [15:0] srd_clamp(input logic [15:0] nom,
                                              input srd_adj_t adj,
                                              input logic [15:0] lim);
        logic signed [17:0] s;
        // Two spare bits hold both the sign and any carry of the sum
        s = $signed({2'b00, nom}) + 18'(adj);
        if (s < 0)
            srd_clamp = 16'h0000;
        else if (s > $signed({2'b00, lim}))
            srd_clamp = lim;
        else
            srd_clamp = s[15:0];
    endfunction : srd_clamp

    // Software-visible settings
    logic [2:0] ctrl_reg;
    logic [15:0] period_reg;
    logic [15:0] nominal_reg;
    logic [7:0] blank_reg;
    logic [7:0] winlen_reg;
    srd_adj_t manual_reg;
    logic [6:0] target_reg;
    logic [15:0] step_reg;
    logic [6:0] flt_thr_reg;
    logic [15:0] flt_step_reg;

    // Sticky events and their mask
    logic [`SRD_ST_W-1:0] status_reg;
    logic [`SRD_ST_W-1:0] mask_reg;

    // Timebase, read path and output flops
    logic [15:0] pcnt_reg;
    logic [15:0] rdata_reg;
    logic irq_reg;
    logic [1:0] pulse_reg;

    // Results of the last closed window, one entry per channel
    logic [6:0] cnt_reg [2];
    srd_adj_t adj_reg [2];

    // Per-channel event strobes gathered into the status word
    logic [1:0] done_set;
    logic [1:0] flt_set;

    // Register write decode and control fields
    wire wr_ctrl = reg_wr && reg_addr == `SRD_A_CTRL;
    wire wr_period = reg_wr && reg_addr == `SRD_A_PERIOD;
    wire wr_nominal = reg_wr && reg_addr == `SRD_A_NOMINAL;
    wire wr_blank = reg_wr && reg_addr == `SRD_A_BLANK;
    wire wr_winlen = reg_wr && reg_addr == `SRD_A_WINLEN;
    wire wr_manual = reg_wr && reg_addr == `SRD_A_MANUAL;
    wire wr_target = reg_wr && reg_addr == `SRD_A_TARGET;
    wire wr_step = reg_wr && reg_addr == `SRD_A_STEP;
    wire wr_flt_thr = reg_wr && reg_addr == `SRD_A_FLT_THR;
    wire wr_flt_step = reg_wr && reg_addr == `SRD_A_FLT_STEP;
    wire wr_status = reg_wr && reg_addr == `SRD_A_STATUS;
    wire wr_mask = reg_wr && reg_addr == `SRD_A_MASK;
    wire run = ctrl_reg[`SRD_B_EN];
    wire auto_mode = ctrl_reg[`SRD_B_AUTO];
    wire flt_en = ctrl_reg[`SRD_B_FLTEN];
    wire [15:0] half = {1'b0, period_reg[15:1]};
    wire pwrap = pcnt_reg >= period_reg - 16'h0001;
    wire [1:0] cond_low = {~controller_conduction_input_one,
                           ~controller_conduction_input_zero};

    // Read selection; unmapped addresses read zero
    wire [15:0] rd_mux =
        reg_addr == `SRD_A_CTRL ? {13'h0000, ctrl_reg} :
        reg_addr == `SRD_A_PERIOD ? period_reg :
        reg_addr == `SRD_A_NOMINAL ? nominal_reg :
        reg_addr == `SRD_A_BLANK ? {8'h00, blank_reg} :
        reg_addr == `SRD_A_WINLEN ? {8'h00, winlen_reg} :
        reg_addr == `SRD_A_MANUAL ? manual_reg :
        reg_addr == `SRD_A_TARGET ? {9'h000, target_reg} :
        reg_addr == `SRD_A_STEP ? step_reg :
        reg_addr == `SRD_A_FLT_THR ? {9'h000, flt_thr_reg} :
        reg_addr == `SRD_A_FLT_STEP ? flt_step_reg :
        reg_addr == `SRD_A_CNT0 ? {9'h000, cnt_reg[0]} :
        reg_addr == `SRD_A_CNT1 ? {9'h000, cnt_reg[1]} :
        reg_addr == `SRD_A_ADJ0 ? adj_reg[0] :
        reg_addr == `SRD_A_ADJ1 ? adj_reg[1] :
        reg_addr == `SRD_A_STATUS ? {12'h000, status_reg} :
        reg_addr == `SRD_A_MASK ? {12'h000, mask_reg} :
        16'h0000;

    // Events set sticky flags; a set in the clearing cycle wins
    wire [`SRD_ST_W-1:0] st_set = {flt_set, done_set};
    wire [`SRD_ST_W-1:0] st_clr = wr_status ? reg_wdata[`SRD_ST_W-1:0]
                                            : {`SRD_ST_W{1'b0}};
    wire [`SRD_ST_W-1:0] status_next = (status_reg & ~st_clr) | st_set;

    // Software registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_reg <= `SRD_RST_CTRL;
            period_reg <= `SRD_RST_PERIOD;
            nominal_reg <= `SRD_RST_NOMINAL;
            blank_reg <= `SRD_RST_BLANK;
            winlen_reg <= `SRD_RST_WINLEN;
            manual_reg <= `SRD_RST_MANUAL;
            target_reg <= `SRD_RST_TARGET;
            step_reg <= `SRD_RST_STEP;
            flt_thr_reg <= `SRD_RST_FLT_THR;
            flt_step_reg <= `SRD_RST_FLT_STEP;
            mask_reg <= {`SRD_ST_W{1'b0}};
        end else if (clk_en) begin
            if (wr_ctrl) ctrl_reg <= reg_wdata[2:0];
            if (wr_period) period_reg <= reg_wdata;
            if (wr_nominal) nominal_reg <= reg_wdata;
            if (wr_blank) blank_reg <= reg_wdata[7:0];
            if (wr_winlen) winlen_reg <= reg_wdata[7:0];
            if (wr_manual) manual_reg <= reg_wdata;
            if (wr_target) target_reg <= reg_wdata[6:0];
            if (wr_step) step_reg <= reg_wdata;
            if (wr_flt_thr) flt_thr_reg <= reg_wdata[6:0];
            if (wr_flt_step) flt_step_reg <= reg_wdata;
            if (wr_mask) mask_reg <= reg_wdata[`SRD_ST_W-1:0];
        end
    end

    // Status, read data one cycle after the strobe, level interrupt
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_reg <= {`SRD_ST_W{1'b0}};
            rdata_reg <= 16'h0000;
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            status_reg <= status_next;
            rdata_reg <= reg_rd ? rd_mux : 16'h0000;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    // Switching period counter; held at zero while disabled
    always_ff @(posedge mclk) begin
        if (sys_rst)
            pcnt_reg <= 16'h0000;
        else if (clk_en)
            pcnt_reg <= (!run || pwrap) ? 16'h0000 : pcnt_reg + 16'h0001;
    end

    // One rectifier channel per half period, each with its own window
    for (genvar c = 0; c < 2; c++) begin : g_ch
        srd_win_t win_reg;
        logic [7:0] tmr_reg;
        logic [6:0] acc_reg;
        logic [15:0] on_reg;
        wire in_half = (c == 0) ? (pcnt_reg < half) : (pcnt_reg >= half);
        wire [15:0] loc = (c == 0) ? pcnt_reg : pcnt_reg - half;
        wire [15:0] start_at = (c == 0) ? 16'h0000 : half;
        wire half_start = run && pcnt_reg == start_at;
        // Correction found last cycle is latched at this half's start
        wire [15:0] on_use = half_start ?
            srd_clamp(nominal_reg, adj_reg[c], half) : on_reg;
        wire pulse_next = run && in_half && loc < on_use;
        // Window starts as this channel's command goes low
        wire fall = pulse_reg[c] && !pulse_next;
        // Saturating low-time accumulation; report is high while gate on
        wire [6:0] acc_cur = (cond_low[c] && acc_reg != `SRD_CNT_MAX) ?
            acc_reg + 7'h01 : acc_reg;
        // Last open cycle; a zero length still gives one sample
        wire closing = win_reg == SRD_OPEN && tmr_reg <= 8'h01;
        // The fault flag is raised in manual mode too, but only the
        // automatic path cuts the on time
        wire fault = flt_en && acc_cur < flt_thr_reg;
        // Next correction: manual, fault cut, or one step toward target
        wire signed [16:0] adj_w = 17'(adj_reg[c]);
        wire signed [16:0] step_w = $signed({1'b0, step_reg});
        wire signed [16:0] fstep_w = $signed({1'b0, flt_step_reg});
        wire srd_adj_t adj_auto =
            fault ? srd_sat(adj_w - fstep_w) :
            acc_cur > target_reg ? srd_sat(adj_w + step_w) :
            acc_cur < target_reg ? srd_sat(adj_w - step_w) :
            adj_reg[c];
        wire srd_adj_t adj_new = auto_mode ? adj_auto : manual_reg;

        // Qualified by the enable so a frozen clock adds no events
        assign done_set[c] = clk_en && closing;
        assign flt_set[c] = clk_en && closing && fault;

        // Gate command and latched on time
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                pulse_reg[c] <= 1'b0;
                on_reg <= 16'h0000;
            end else if (clk_en) begin
                pulse_reg[c] <= pulse_next;
                on_reg <= on_use;
            end
        end

        // Blanking then open window; counts only inside the window
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                win_reg <= SRD_IDLE;
                tmr_reg <= 8'h00;
                acc_reg <= 7'h00;
                cnt_reg[c] <= 7'h00;
                adj_reg[c] <= 16'h0000;
            end else if (clk_en) begin
                unique case (win_reg)
                    SRD_IDLE: begin
                        acc_reg <= 7'h00;
                        if (fall && blank_reg == 8'h00) begin
                            win_reg <= SRD_OPEN;
                            tmr_reg <= winlen_reg;
                        end else if (fall) begin
                            win_reg <= SRD_BLANK;
                            tmr_reg <= blank_reg;
                        end
                    end
                    SRD_BLANK: begin
                        tmr_reg <= tmr_reg - 8'h01;
                        if (tmr_reg <= 8'h01) begin
                            win_reg <= SRD_OPEN;
                            tmr_reg <= winlen_reg;
                        end
                    end
                    SRD_OPEN: begin
                        acc_reg <= acc_cur;
                        tmr_reg <= tmr_reg - 8'h01;
                        if (closing) begin
                            win_reg <= SRD_IDLE;
                            cnt_reg[c] <= acc_cur;
                            adj_reg[c] <= adj_new;
                        end
                    end
                endcase
            end
        end
    end

    // Every output comes straight from a flip-flop
    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;
    assign rectifier_zero_pulse = pulse_reg[0];
    assign rectifier_one_pulse = pulse_reg[1];

endmodule : srd_ctrl

/* dv/srd_ctrl_sva.sv */
// Port-level checks of the conduction-sense dead-time controller.
// Assumes one mclk domain with synchronous active-high sys_rst.
`timescale 1ns/1ps
`include "srd_map.svh"
module srd_ctrl_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic irq,
    input wire logic controller_conduction_input_zero,
    input wire logic controller_conduction_input_one,
    input wire logic rectifier_zero_pulse,
    input wire logic rectifier_one_pulse
);
    // Accepted accesses of interest
    wire rd_cnt0 = clk_en && reg_rd && reg_addr == `SRD_A_CNT0;
    wire rd_cnt1 = clk_en && reg_rd && reg_addr == `SRD_A_CNT1;
    wire rd_st = clk_en && reg_rd && reg_addr == `SRD_A_STATUS;
    wire rd_man = clk_en && reg_rd && reg_addr == `SRD_A_MANUAL;
    wire wr_man = clk_en && reg_wr && reg_addr == `SRD_A_MANUAL;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Channels own alternate halves, so pulses never overlap
    pulse_excl_a: assert property (!(rectifier_zero_pulse && rectifier_one_pulse))
        else $error("both rectifier pulses high");
    cnt0_range_a: assert property ($past(rd_cnt0) |-> reg_rdata[15:7] == 9'h000)
        else $error("channel zero count above range");
    cnt1_range_a: assert property ($past(rd_cnt1) |-> reg_rdata[15:7] == 9'h000)
        else $error("channel one count above range");
    status_width_a: assert property ($past(rd_st) |-> reg_rdata[15:4] == 12'h000)
        else $error("status has stray bits");
    read_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    // A frozen clock enable must hold both rectifier pulses and the interrupt
    freeze_hold_a: assert property (!$past(clk_en) && !$past(sys_rst) |->
        $stable(rectifier_zero_pulse) && $stable(rectifier_one_pulse) && $stable(irq))
        else $error("outputs moved while frozen");
    manual_echo_a: assert property ($past(wr_man, 3) && $past(rd_man) |->
        reg_rdata == $past(reg_wdata, 3)) else $error("manual value not kept");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst && clk_en |=>
        !rectifier_zero_pulse && !rectifier_one_pulse && !irq)
        else $error("outputs active after reset");
endmodule : srd_ctrl_sva

/* dv/srd_driver_model.sv */
// Behavioural gate driver that reports body-diode conduction.
// Assumes command and drain sense change just after mclk edges.
`timescale 1ns/1ps
module srd_driver_model (
    input wire logic cmd,
    input int drain_sense_input,
    input int vcc_mv,
    output logic diode_conduction_report,
    output logic gate
);
    logic undervoltage_lockout = 1'b1;
    logic armed = 1'b0;
    logic detect;
    // Supply hysteresis keeps a noisy rail from chattering
    always @(vcc_mv)
        if (vcc_mv > 3800) undervoltage_lockout = 1'b0;
        else if (vcc_mv < 3560) undervoltage_lockout = 1'b1;
    // Comparator stays dead until the rail has risen
    assign detect = !undervoltage_lockout &&
        drain_sense_input < -150;
    // Turn-on waits for conduction, turn-off follows the command alone
    always @(cmd or detect)
        if (!cmd) armed = 1'b0;
        else if (detect) armed = 1'b1;
    assign gate = !undervoltage_lockout && cmd && armed;
    // Report blanked high while the gate drives, low in lockout
    assign diode_conduction_report = !undervoltage_lockout &&
        (gate || !detect);
endmodule : srd_driver_model

/* dv/test_sr_diode_conduction_sense_adjust.sv */
// Self-checking bench for the conduction-sense dead-time controller.
// Assumes two driver models on the report pins and mclk at 100 MHz.
`timescale 1ns/1ps
`include "srd_map.svh"
module test_sr_diode_conduction_sense_adjust;
    logic mclk = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    logic irq, controller_conduction_input_zero;
    logic controller_conduction_input_one;
    logic rectifier_zero_pulse, rectifier_one_pulse;
    int drain0 = 2000, drain1 = 2000, vcc0 = 0, vcc1 = 0;
    int seed = 17, miscompares = 0, comparisons = 0;
    bit lock1 = 1;
    logic [15:0] rst_val [16] = '{16'(`SRD_RST_CTRL), `SRD_RST_PERIOD,
        `SRD_RST_NOMINAL, 16'(`SRD_RST_BLANK), 16'(`SRD_RST_WINLEN),
        `SRD_RST_MANUAL, 16'(`SRD_RST_TARGET), `SRD_RST_STEP,
        16'(`SRD_RST_FLT_THR), `SRD_RST_FLT_STEP, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    always #5 mclk = ~mclk;
    srd_ctrl srd_ctrl_inst (.mclk, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq, .controller_conduction_input_zero,
        .controller_conduction_input_one, .rectifier_zero_pulse,
        .rectifier_one_pulse);
    // One driver per rectifier channel
    srd_driver_model drv0_inst (.cmd(rectifier_zero_pulse), .vcc_mv(vcc0),
        .drain_sense_input(drain0), .gate(),
        .diode_conduction_report(controller_conduction_input_zero));
    srd_driver_model drv1_inst (.cmd(rectifier_one_pulse), .vcc_mv(vcc1),
        .drain_sense_input(drain1), .gate(),
        .diode_conduction_report(controller_conduction_input_one));
    function automatic int cnt_of(bit c, int w);
        return c ? (w > 127 ? 127 : (w < 1 ? 1 : w)) : 0;
    endfunction : cnt_of
    function automatic int exp_adj(int k, bit am, bit fe, int tgt, int man);
        if (!am) return man;
        if (fe && k < `SRD_RST_FLT_THR) return -int'(`SRD_RST_FLT_STEP);
        if (k > tgt) return int'(`SRD_RST_STEP);
        if (k < tgt) return -int'(`SRD_RST_STEP);
        return 0;
    endfunction : exp_adj
    task chk(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bus cycles: strobe for one cycle, read data sampled next cycle
    task wr(logic [7:0] a, logic [15:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(logic [7:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task wait_irq;
        for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk) #1;
        chk({15'h0000, irq}, 16'h0001);
    endtask : wait_irq
    // High time of the next channel zero pulse, in cycles
    task width(output int n);
        n = 0;
        for (int i = 0; i < 2000 && rectifier_zero_pulse !== 1'b1; i++)
            @(posedge mclk) #1;
        while (rectifier_zero_pulse === 1'b1 && n < 300) begin
            @(posedge mclk) #1;
            n++;
        end
    endtask : width
    // Reset, program, run one window per channel and check the outcome
    task run_case(bit am, bit fe, int b, int w, bit c0, bit c1, int v1);
        int man, tgt, nom, n, k0, k1, a0, a1;
        man = $random(seed) % 64;
        tgt = 1 + {$random(seed)} % 20;
        nom = 64 + {$random(seed)} % 60;
        if (v1 > 3800) lock1 = 0;
        else if (v1 < 3560) lock1 = 1;
        k0 = cnt_of(c0, w);
        k1 = cnt_of(c1 || lock1, w); // Lockout reads as conduction
        a0 = exp_adj(k0, am, fe, tgt, man);
        a1 = exp_adj(k1, am, fe, tgt, man);
        drain0 <= c0 ? -500 : 2000;
        drain1 <= c1 ? -500 : 2000;
        vcc1 <= v1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge mclk);
        clk_en <= 1'b1;
        wr(`SRD_A_PERIOD, 16'h0190);
        wr(`SRD_A_NOMINAL, 16'(nom));
        wr(`SRD_A_BLANK, 16'(b));
        wr(`SRD_A_WINLEN, 16'(w));
        wr(`SRD_A_TARGET, 16'(tgt));
        wr(`SRD_A_MANUAL, 16'(man));
        rd(`SRD_A_MANUAL, d);
        chk(d, 16'(man));
        wr(`SRD_A_MASK, 16'h0001);
        wr(`SRD_A_CTRL, {13'h0000, fe, am, 1'b1});
        wait_irq;
        rd(`SRD_A_CNT0, d);
        chk(d, 16'(k0));
        rd(`SRD_A_ADJ0, d);
        chk(d, 16'(a0));
        rd(`SRD_A_STATUS, d);
        chk(d & 16'h0005, fe && k0 < 1 ? 16'h0005 : 16'h0001);
        wr(`SRD_A_STATUS, 16'h0005);
        rd(`SRD_A_STATUS, d);
        chk(d & 16'h0005, 16'h0000);
        width(n);
        chk(16'(n), 16'(nom + a0));
        chk({15'h0000, irq}, 16'h0000);
        wr(`SRD_A_MASK, 16'h0002);
        wait_irq;
        rd(`SRD_A_CNT1, d);
        chk(d, 16'(k1));
        rd(`SRD_A_ADJ1, d);
        chk(d, 16'(a1));
        rd(`SRD_A_STATUS, d);
        chk(d & 16'h000A, fe && k1 < 1 ? 16'h000A : 16'h0002);
        $display("case done at %0t", $time);
    endtask : run_case
    task finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    // Main sequence: reset values, corner cases, then random cases
    initial begin
        vcc0 <= 5000;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 17; a++) begin
            rd(8'(a), d);
            chk(d, a < 16 ? rst_val[a] : 16'h0000);
        end
        $display("reset values done at %0t", $time);
        run_case(1, 1, 1, 12, 1, 0, 3700);
        run_case(1, 0, 0, 130, 1, 1, 5000);
        run_case(0, 1, 2, 0, 0, 1, 3700);
        repeat (4) run_case(1'($random(seed)), 1'($random(seed)),
            {$random(seed)} % 4, 1 + {$random(seed)} % 40,
            1'($random(seed)), 1'($random(seed)), 5000);
        finish_test;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        miscompares++;
        finish_test;
    end
endmodule : test_sr_diode_conduction_sense_adjust
bind srd_ctrl srd_ctrl_sva srd_ctrl_sva_inst (.mclk, .sys_rst, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .controller_conduction_input_zero, .controller_conduction_input_one,
    .rectifier_zero_pulse, .rectifier_one_pulse);
